// File: hw/lsdc_consts.vh
`ifndef LSDC_CONSTS_VH
`define LSDC_CONSTS_VH
// Port address that reaches the mode register
`define LSDC_MODE_PORT 4'hB
// Mode register reset value
`define LSDC_MODE_RESET 4'h0
// Mode field positions
`define LSDC_ROW_BIT 3
`define LSDC_SCAN_BIT 2
// Parallel-output mode code in the low three bits
`define LSDC_MODE_PAR 3'h1
// Scan-length codes
`define LSDC_LEN_4 2'h0
`define LSDC_LEN_5 2'h1
`define LSDC_LEN_6 2'h2
`define LSDC_LEN_8 2'h3
// Machine cycles each digit is driven
`define LSDC_DIGIT_CYCLES 13
// Buffer columns for the parallel-output pair
`define LSDC_PAR_LO_COL 4'hE
`define LSDC_PAR_HI_COL 4'hF
`endif

// File: hw/lsdc_ram.v
`timescale 1ns/10ps
`default_nettype none
// Display-buffer RAM, two read ports with registered outputs
module lsdc_ram #(
    parameter ADDR_W = 6,
    parameter DEPTH = 48
) (
    input wire sys_clk,
    input wire wr_en,
    input wire [ADDR_W-1:0] wr_addr,
    input wire [3:0] wr_data,
    input wire [ADDR_W-1:0] rd_addr_a,
    input wire [ADDR_W-1:0] rd_addr_b,
    output reg [3:0] rd_data_a,
    output reg [3:0] rd_data_b
);
    reg [3:0] mem [0:DEPTH-1];

    // Write port and registered reads
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end
endmodule
`default_nettype wire

// File: hw/lsdc_ctrl.v
// Notes on behaviour
// RULE1: Selector decodes digit index, copies its RAM nibble pair to segments, enables its drive.
// RULE2: Each digit is driven 13 machine cycles, then off, then next digit, forever.
// RULE3: Mode register loads accumulator on port-output instruction with port address B.
// RULE4: Mode 0000 stops scan, segments all high, digit drives 0-5 off.
// RULE5: Mode 0001 latches columns E and F onto segments, drives 0-3 off.
// RULE6: Mode bit 3 picks buffer row 0 or row 2.
// RULE7: Low bits pick 4, 5, 6 or 8 digits when bit 2 set.
// RULE8: Mode bit 2 selects scanning or latched parallel output.
// RULE9: In 8-digit mode strobes 6 and 7 drive port 4 bits 0 and 1.
// RULE10: Digit lines 4 and 5 follow port 2 bits when not scanned; the code does this only in parallel mode and drives them off otherwise.
// RULE11: Scan runs on its own, never stalls the processor.
// RULE12: New mode takes effect right after the write.
// RULE13: Digit n uses offsets 2n (segments 0-3) and 2n+1 (segments 4-7).
// RULE14: Unused codes behave as reset mode; register clears to 0000 on reset.
`include "lsdc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module lsdc_ctrl #(
    parameter DIGIT_CYCLES = `LSDC_DIGIT_CYCLES
) (
    input wire sys_clk,
    input wire rst_n,
    input wire mcycle_pulse,
    input wire port_output_instruction,
    input wire [3:0] port_addr,
    input wire [3:0] acc_data,
    input wire ram_wr_en,
    input wire [5:0] ram_wr_addr,
    input wire [3:0] ram_wr_data,
    input wire [1:0] high_current_out_bits,
    input wire [1:0] bidir_port_out,
    input wire [1:0] bidir_port_oe,
    output reg [7:0] segment_lines,
    output reg [5:0] digit_drive_lines,
    output reg [1:0] bidir_port_low_bits,
    output reg [1:0] bidir_port_low_bits_oe,
    output reg [3:0] display_mode_select
);
    localparam ST_IDLE = 2'h0;
    localparam ST_LOAD = 2'h1;
    localparam ST_DRIVE = 2'h2;
    localparam ST_FETCH = 2'h3;

    reg [1:0] state;
    reg [2:0] digit_idx;
    reg [4:0] cyc_cnt;
    reg [2:0] last_digit;
    reg [5:0] rd_addr_a;
    reg [5:0] rd_addr_b;
    reg [7:0] strobe;
    reg scan_mode;
    reg par_mode;
    reg [1:0] row;
    wire [3:0] rd_data_a;
    wire [3:0] rd_data_b;
    wire mode_wr;

    // Mode register write decode [RULE3]
    assign mode_wr = port_output_instruction && (port_addr == `LSDC_MODE_PORT);

    // Display buffer storage
    lsdc_ram #(
        .ADDR_W(6),
        .DEPTH(48)
    ) u_ram (
        .sys_clk(sys_clk),
        .wr_en(ram_wr_en),
        .wr_addr(ram_wr_addr),
        .wr_data(ram_wr_data),
        .rd_addr_a(rd_addr_a),
        .rd_addr_b(rd_addr_b),
        .rd_data_a(rd_data_a),
        .rd_data_b(rd_data_b)
    );

    // Mode decode from the register
    always @* begin
        scan_mode = display_mode_select[`LSDC_SCAN_BIT]; // [RULE8]
        par_mode = !display_mode_select[`LSDC_SCAN_BIT] &&
            (display_mode_select[2:0] == `LSDC_MODE_PAR); // [RULE5] [RULE14]
        row = display_mode_select[`LSDC_ROW_BIT] ? 2'h2 : 2'h0; // [RULE6]
        case (display_mode_select[1:0])
            `LSDC_LEN_4: last_digit = 3'h3;
            `LSDC_LEN_5: last_digit = 3'h4;
            `LSDC_LEN_6: last_digit = 3'h5;
            `LSDC_LEN_8: last_digit = 3'h7;
            default: last_digit = 3'h3;
        endcase // [RULE7]
    end

    // Buffer address of the current digit pair
    always @* begin
        if (par_mode) begin
            rd_addr_a = {row, `LSDC_PAR_LO_COL};
            rd_addr_b = {row, `LSDC_PAR_HI_COL};
        end else begin
            rd_addr_a = {row, digit_idx, 1'b0}; // [RULE13]
            rd_addr_b = {row, digit_idx, 1'b1};
        end
    end

    // One-hot digit decoder, only while the digit is being driven
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_dec
            always @* begin
                strobe[gi] = scan_mode && (state == ST_DRIVE) && (digit_idx == gi); // [RULE1]
            end
        end
    endgenerate

    // Scan sequencer; a mode write restarts it at digit 0 at once
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            display_mode_select <= `LSDC_MODE_RESET; // [RULE14]
            state <= ST_IDLE;
            digit_idx <= 3'h0;
            cyc_cnt <= 5'h00;
        end else if (mode_wr) begin
            display_mode_select <= acc_data; // [RULE3] [RULE12]
            state <= ST_IDLE;
            digit_idx <= 3'h0;
            cyc_cnt <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (scan_mode) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // RAM read data lands here; drive starts next
                    state <= ST_DRIVE;
                    cyc_cnt <= 5'h00;
                end
                ST_DRIVE: begin
                    if (!scan_mode) begin
                        state <= ST_IDLE;
                    end else if (mcycle_pulse) begin
                        if (cyc_cnt == DIGIT_CYCLES - 1) begin
                            // Drive drops, selector advances [RULE2]
                            // One fetch cycle so the registered read sees the new digit
                            state <= ST_FETCH;
                            cyc_cnt <= 5'h00;
                            digit_idx <= (digit_idx == last_digit) ? 3'h0 : digit_idx + 3'h1; // [RULE7]
                        end else begin
                            cyc_cnt <= cyc_cnt + 5'h01;
                        end
                    end
                end
                ST_FETCH: begin
                    // Buffer read of the new digit pair settles [RULE13]
                    state <= ST_LOAD;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Registered pin outputs; buffer reads are free-running so the CPU never waits [RULE11]
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            segment_lines <= 8'hFF;
            digit_drive_lines <= 6'h00;
            bidir_port_low_bits <= 2'h0;
            bidir_port_low_bits_oe <= 2'h0;
        end else begin
            if (scan_mode) begin
                if (state == ST_LOAD) begin
                    segment_lines <= {rd_data_b, rd_data_a}; // [RULE1] [RULE13]
                end
            end else if (par_mode) begin
                segment_lines <= {rd_data_b, rd_data_a}; // [RULE5]
            end else begin
                segment_lines <= 8'hFF; // [RULE4] [RULE14]
            end
            digit_drive_lines[3:0] <= strobe[3:0]; // [RULE4] [RULE5]
            // Lines 4 and 5 fall back to port 2 when unscanned in parallel mode, else stay off [RULE10]
            if (scan_mode && display_mode_select[1:0] != `LSDC_LEN_4) begin
                digit_drive_lines[4] <= strobe[4];
            end else begin
                digit_drive_lines[4] <= par_mode ? high_current_out_bits[0] : 1'b0;
            end
            if (scan_mode && display_mode_select[1]) begin
                digit_drive_lines[5] <= strobe[5];
            end else begin
                digit_drive_lines[5] <= par_mode ? high_current_out_bits[1] : 1'b0;
            end
            // Extra strobes take over port 4 low bits [RULE9]
            if (scan_mode && display_mode_select[1:0] == `LSDC_LEN_8) begin
                bidir_port_low_bits <= strobe[7:6];
                bidir_port_low_bits_oe <= 2'h3;
            end else begin
                bidir_port_low_bits <= bidir_port_out;
                bidir_port_low_bits_oe <= bidir_port_oe;
            end
        end
    end
endmodule
`default_nettype wire

// File: test/lsdc_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module lsdc_ctrl_chk #(parameter DIGIT_CYCLES = 13) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic port_output_instruction,
    input wire logic [3:0] port_addr,
    input wire logic [3:0] acc_data,
    input wire logic [7:0] segment_lines,
    input wire logic [5:0] digit_drive_lines,
    input wire logic [3:0] display_mode_select
);
    logic [7:0] cnt;
    logic cut;
    // Decoded write and mode classes
    wire wr = port_output_instruction && port_addr == 4'hB;
    wire idle = display_mode_select inside {4'h0, 4'h2, 4'h3, 4'h8, 4'hA, 4'hB};
    wire [2:0] low = display_mode_select[2:0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Length of digit 0 slot; a mode write cuts a slot short, so skip those
    always_ff @(posedge sys_clk) begin
        cnt <= (!rst_n || !digit_drive_lines[0]) ? 8'h00 : cnt + 8'h01;
        cut <= !rst_n || wr || (cut && !$rose(digit_drive_lines[0]));
    end
    property p_load; wr |=> display_mode_select == $past(acc_data); endproperty
    a_load: assert property (p_load)
        else $error("mode write lost");
    property p_keep; !wr |=> $stable(display_mode_select); endproperty
    a_keep: assert property (p_keep)
        else $error("mode changed without write");
    property p_off; (display_mode_select == 4'h0)[*4] |-> segment_lines == 8'hFF && digit_drive_lines == 6'h00;
    endproperty
    a_off: assert property (p_off)
        else $error("reset mode outputs wrong");
    property p_unused; idle[*4] |-> segment_lines == 8'hFF && digit_drive_lines == 6'h00; endproperty
    a_unused: assert property (p_unused)
        else $error("unused mode outputs wrong");
    property p_one; $onehot0(digit_drive_lines); endproperty
    a_one: assert property (p_one)
        else $error("two digits driven");
    property p_par; (low == 3'h1)[*4] |-> digit_drive_lines[3:0] == 4'h0; endproperty
    a_par: assert property (p_par)
        else $error("digit on in parallel mode");
    property p_four; (low == 3'h4)[*4] |-> digit_drive_lines[5:4] == 2'b00; endproperty
    a_four: assert property (p_four)
        else $error("digit beyond four");
    property p_slot; $fell(digit_drive_lines[0]) && !cut && !$past(wr) |-> cnt == DIGIT_CYCLES; endproperty
    a_slot: assert property (p_slot)
        else $error("digit slot length wrong");
    c_slot: cover property ($fell(digit_drive_lines[0]) && !cut);
    c_eight: cover property (low == 3'h7 && digit_drive_lines[5]);
    c_par: cover property (low == 3'h1 && segment_lines != 8'hFF);
endmodule
bind lsdc_ctrl lsdc_ctrl_chk #(.DIGIT_CYCLES(DIGIT_CYCLES)) u_chk (.sys_clk, .rst_n, .port_output_instruction,
    .port_addr, .acc_data, .segment_lines, .digit_drive_lines, .display_mode_select);
`default_nettype wire

// File: test/lsdc_led_panel.sv
`timescale 1ns/10ps
`default_nettype none
module lsdc_led_panel (
    input wire logic sys_clk,
    input wire logic [7:0] segment_lines,
    input wire logic [7:0] digit_on,
    output logic [7:0][7:0] lit
);
    // Common anode: a cathode glows when low while its digit is driven
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (digit_on[i]) begin
                lit[i] <= ~segment_lines;
            end
        end
    end
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module tb_top;
    localparam int DC = 13;
    logic sys_clk = 0, rst_n = 0, poi = 0, wen = 0;
    logic [3:0] port_addr = 0, acc_data = 0, wdat = 0, mode, md;
    logic [5:0] waddr = 0, digit_drive_lines;
    logic [1:0] hc = 2'b10, p4, p4_oe;
    logic [7:0] segment_lines, seen;
    logic [7:0][7:0] lit;
    logic [3:0] m [0:47];
    logic [3:0] bad [5] = '{4'h2, 4'h3, 4'h8, 4'hA, 4'hB};
    int nds [4] = '{4, 5, 6, 8};
    int fails = 0, n_tests = 0, cyc = 0, nd, base;
    wire [7:0] digit_on = {p4 & p4_oe, digit_drive_lines};
    initial forever #2.5 sys_clk = ~sys_clk;
    lsdc_ctrl #(.DIGIT_CYCLES(DC)) dut (.sys_clk, .rst_n, .mcycle_pulse(1'b1), .port_output_instruction(poi),
        .port_addr, .acc_data, .ram_wr_en(wen), .ram_wr_addr(waddr), .ram_wr_data(wdat),
        .high_current_out_bits(hc), .bidir_port_out(2'b00), .bidir_port_oe(2'b00), .segment_lines,
        .digit_drive_lines, .bidir_port_low_bits(p4), .bidir_port_low_bits_oe(p4_oe), .display_mode_select(mode));
    lsdc_led_panel panel (.sys_clk, .segment_lines, .digit_on, .lit);
    // Digits seen lit, and a ceiling well above the run length
    always @(posedge sys_clk) begin
        seen <= seen | digit_on;
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One display RAM write, mirrored for expectations
    task automatic wr_ram(input logic [5:0] a, input logic [3:0] d);
        @(negedge sys_clk);
        wen = 1;
        waddr = a;
        wdat = d;
        m[a] = d;
        @(negedge sys_clk);
        wen = 0;
    endtask
    // Port-output instruction, then let the new mode settle
    task automatic wr_mode(input logic [3:0] p, input logic [3:0] v);
        @(negedge sys_clk);
        poi = 1;
        port_addr = p;
        acc_data = v;
        @(negedge sys_clk);
        poi = 0;
        repeat (4) @(negedge sys_clk);
        seen = 0;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n = 1;
        `CHK({mode, segment_lines, digit_drive_lines}, {4'h0, 8'hFF, 6'h00})
        for (int i = 0; i < 48; i++) wr_ram(i[5:0], 4'(i * 7 + 3));
        wr_mode(4'hA, 4'h4);
        `CHK(mode, 4'h0)
        wr_mode(4'hB, 4'h1);
        `CHK({digit_drive_lines, segment_lines}, {hc, 4'h0, m[15], m[14]})
        wr_ram(6'h0E, 4'hC);
        repeat (3) @(negedge sys_clk);
        `CHK(segment_lines[3:0], 4'hC)
        wr_mode(4'hB, 4'h9);
        `CHK(segment_lines, {m[47], m[46]})
        for (int k = 0; k < 8; k++) begin
            md = {k[2], 1'b1, k[1:0]};
            nd = nds[k % 4];
            base = k[2] ? 32 : 0;
            wr_mode(4'hB, md);
            repeat (8 * (DC + 3)) @(negedge sys_clk);
            `CHK(seen, 8'((1 << nd) - 1))
            for (int n = 0; n < nd; n++) `CHK(lit[n], ~{m[base + 2 * n + 1], m[base + 2 * n]})
        end
        foreach (bad[i]) begin
            wr_mode(4'hB, bad[i]);
            `CHK({segment_lines, digit_drive_lines}, {8'hFF, 6'h00})
        end
        wr_mode(4'hB, 4'hF);
        wr_mode(4'hB, 4'h0);
        `CHK({segment_lines, digit_drive_lines}, {8'hFF, 6'h00})
        finish_test();
    end
endmodule
`default_nettype wire
